// >>> rtcpit_pkg.sv
// Constants for the timekeeping counter and tick timer block.
// Assumes an Avalon-MM host with word addressing of byte registers.
package rtcpit_pkg;
   // Register indices; byte address is four times the index
   localparam logic [4:0] IDX_CONTROL     = 5'h00;
   localparam logic [4:0] IDX_SYNC_STATE  = 5'h01;
   localparam logic [4:0] IDX_ENABLE      = 5'h02;
   localparam logic [4:0] IDX_FLAGS       = 5'h03;
   localparam logic [4:0] IDX_STAGING     = 5'h04;
   localparam logic [4:0] IDX_HALT        = 5'h05;
   localparam logic [4:0] IDX_SOURCE      = 5'h07;
   localparam logic [4:0] IDX_COUNT_LO    = 5'h08;
   localparam logic [4:0] IDX_COUNT_HI    = 5'h09;
   localparam logic [4:0] IDX_LIMIT_LO    = 5'h0a;
   localparam logic [4:0] IDX_LIMIT_HI    = 5'h0b;
   localparam logic [4:0] IDX_MATCH_LO    = 5'h0c;
   localparam logic [4:0] IDX_MATCH_HI    = 5'h0d;
   localparam logic [4:0] IDX_TICK_CTRL   = 5'h10;
   localparam logic [4:0] IDX_TICK_SYNC   = 5'h11;
   localparam logic [4:0] IDX_TICK_ENABLE = 5'h12;
   localparam logic [4:0] IDX_TICK_FLAGS  = 5'h13;
   localparam logic [4:0] IDX_TICK_HALT   = 5'h15;
   // Control field positions
   localparam int CTRL_STANDBY_BIT = 7;
   localparam int CTRL_PRESC_HI    = 6;
   localparam int CTRL_PRESC_LO    = 3;
   localparam int CTRL_ENABLE_BIT  = 0;
   localparam int TICK_PERIOD_HI   = 6;
   localparam int TICK_PERIOD_LO   = 3;
   localparam int TICK_ENABLE_BIT  = 0;
   // Flag and enable bit positions
   localparam int WRAP_BIT  = 0;
   localparam int MATCH_BIT = 1;
   localparam int TICK_BIT  = 0;
   // Sync channel numbers 0 to 3 equal the sync_state bit positions; channel 4 is tick sync bit 0
   localparam int SYNC_CONTROL = 0;
   localparam int SYNC_COUNT   = 1;
   localparam int SYNC_LIMIT   = 2;
   localparam int SYNC_MATCH   = 3;
   localparam int SYNC_TICK    = 4;
   localparam int SYNC_CHANNELS = 5;
   // Reset values
   localparam logic [7:0]  RESET_BYTE  = 8'h00;
   localparam logic [15:0] RESET_LIMIT = 16'hffff;
   localparam logic [15:0] RESET_WORD  = 16'h0000;
   // Slow clock edges from register update to effect
   localparam logic [1:0]  SYNC_SLOW_EDGES = 2'h2;
   localparam int PRESC_WIDTH = 15;
endpackage : rtcpit_pkg

// >>> rtcpit_top.sv
// Timekeeping counter with shared prescaler and periodic tick timer.
// Assumes an Avalon-MM master on clk_in and a slow timebase on a pin.
// Functional notes
// - Set wrap flag when counter hits limit and wraps to zero; counter request.
// - Set match flag when counter equals match value; shares counter request.
// - Set tick flag each elapsed tick period; separate tick request.
// - Flags set on every event, enabled or not.
// - Request asserted while a flag and its enable are both set.
// - Counter runs in idle; in standby only with keep-running bit.
// - Tick timer runs in every sleep mode.
// - Counting runs on slow timebase; control, count, limit, match and tick control writes apply after crossing over.
// - Status bit 3 high while match value is synchronising.
// - Status bit 2 high while limit value is synchronising.
// - Status bit 1 high while count value is synchronising.
// - Status bit 0 high while control write is synchronising.
// - Tick status bit 0 high while tick control write synchronises.
// - Control: keep-running bit 7, prescaler select 6:3, enable bit 0.
// - Prescaler select n divides slow clock by two to the n.
// - Control write takes effect two slow clock cycles later.
// - Counter counts only while enable bit is one.
// - Writing one clears a flag; writing zero leaves it.
`timescale 1ns/10ps
module rtcpit_top (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   // Avalon-MM slave
   input  wire logic [6:0]  address_in,
   input  wire logic        read_in,
   input  wire logic        write_in,
   input  wire logic [31:0] writedata_in,
   input  wire logic [3:0]  byteenable_in,
   output logic      [31:0] readdata_out,
   output logic             waitrequest_out,
   // Timebase and system state
   input  wire logic        slow_clk_in,
   input  wire logic        standby_in,
   input  wire logic        debug_halt_in,
   // Interrupt requests
   output logic             counter_irq_out,
   output logic             tick_irq_out
);
   localparam int PW = rtcpit_pkg::PRESC_WIDTH;
   localparam int NS = rtcpit_pkg::SYNC_CHANNELS;

   // Reset release and timebase synchronisers
   logic rst_meta;
   logic rst_sync_b;
   logic slow_meta;
   logic slow_sync;
   logic slow_prev;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_meta   <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta   <= 1'b1;
         rst_sync_b <= rst_meta;
      end
   end

   always_ff @(posedge clk_in or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         slow_meta <= 1'b0;
         slow_sync <= 1'b0;
         slow_prev <= 1'b0;
      end else begin
         slow_meta <= slow_clk_in;
         slow_sync <= slow_meta;
         slow_prev <= slow_sync;
      end
   end

   // One bus cycle per slow timebase rising edge
   wire slow_edge = slow_sync & ~slow_prev;

   // Bus-side registers
   logic [7:0]  timekeeper_control;
   logic [7:0]  event_enable;
   logic [1:0]  event_flags;
   logic [7:0]  byte_staging;
   logic [7:0]  halt_behaviour;
   logic [7:0]  source_select;
   logic [15:0] wrap_limit;
   logic [15:0] match_value;
   logic [15:0] count_written;
   logic [7:0]  tick_control;
   logic [7:0]  tick_event_enable;
   logic        tick_event_flag;
   logic [7:0]  tick_halt_behaviour;

   // Slow-side applied copies
   logic [7:0]  applied_control;
   logic [15:0] applied_limit;
   logic [15:0] applied_match;
   logic [7:0]  applied_tick;
   logic [15:0] running_count;
   logic [PW-1:0] prescaler;

   // Bus access decode
   wire [4:0] idx       = address_in[6:2];
   wire       req       = (read_in | write_in) & waitrequest_out;
   wire       done      = (read_in | write_in) & ~waitrequest_out;
   wire       wr        = write_in & ~waitrequest_out & byteenable_in[0];
   wire [7:0] wd        = writedata_in[7:0];
   wire       wr_ctrl   = wr & (idx == rtcpit_pkg::IDX_CONTROL);
   wire       wr_en     = wr & (idx == rtcpit_pkg::IDX_ENABLE);
   wire       wr_flags  = wr & (idx == rtcpit_pkg::IDX_FLAGS);
   wire       wr_stage  = wr & (idx == rtcpit_pkg::IDX_STAGING);
   wire       wr_halt   = wr & (idx == rtcpit_pkg::IDX_HALT);
   wire       wr_src    = wr & (idx == rtcpit_pkg::IDX_SOURCE);
   wire       wr_cnt_lo = wr & (idx == rtcpit_pkg::IDX_COUNT_LO);
   wire       wr_cnt_hi = wr & (idx == rtcpit_pkg::IDX_COUNT_HI);
   wire       wr_lim_lo = wr & (idx == rtcpit_pkg::IDX_LIMIT_LO);
   wire       wr_lim_hi = wr & (idx == rtcpit_pkg::IDX_LIMIT_HI);
   wire       wr_mat_lo = wr & (idx == rtcpit_pkg::IDX_MATCH_LO);
   wire       wr_mat_hi = wr & (idx == rtcpit_pkg::IDX_MATCH_HI);
   wire       wr_tick   = wr & (idx == rtcpit_pkg::IDX_TICK_CTRL);
   wire       wr_ten    = wr & (idx == rtcpit_pkg::IDX_TICK_ENABLE);
   wire       wr_tflag  = wr & (idx == rtcpit_pkg::IDX_TICK_FLAGS);
   wire       wr_thalt  = wr & (idx == rtcpit_pkg::IDX_TICK_HALT);

   // Synchronisation channels: busy set by write, cleared after two slow edges
   wire [NS-1:0] sync_start;
   logic [NS-1:0] sync_busy;
   wire [NS-1:0] sync_apply;

   assign sync_start[rtcpit_pkg::SYNC_CONTROL] = wr_ctrl;
   assign sync_start[rtcpit_pkg::SYNC_COUNT]   = wr_cnt_lo | wr_cnt_hi;
   assign sync_start[rtcpit_pkg::SYNC_LIMIT]   = wr_lim_lo | wr_lim_hi;
   assign sync_start[rtcpit_pkg::SYNC_MATCH]   = wr_mat_lo | wr_mat_hi;
   assign sync_start[rtcpit_pkg::SYNC_TICK]    = wr_tick;

   genvar g;
   generate
      for (g = 0; g < NS; g++) begin : g_sync
         logic [1:0] edges;
         assign sync_apply[g] = sync_busy[g] & ~sync_start[g] & slow_edge
                                & (edges == rtcpit_pkg::SYNC_SLOW_EDGES - 2'h1);
         always_ff @(posedge clk_in or negedge rst_sync_b) begin
            if (!rst_sync_b) begin
               sync_busy[g] <= 1'b0;
               edges        <= 2'h0;
            end else if (sync_start[g]) begin
               sync_busy[g] <= 1'b1;
               edges        <= 2'h0;
            end else if (sync_apply[g]) begin
               sync_busy[g] <= 1'b0;
               edges        <= 2'h0;
            end else if (sync_busy[g] & slow_edge) begin
               edges        <= edges + 2'h1;
            end
         end
      end
   endgenerate

   // Applied control fields
   wire       cnt_on     = applied_control[rtcpit_pkg::CTRL_ENABLE_BIT];
   wire       keep_stby  = applied_control[rtcpit_pkg::CTRL_STANDBY_BIT];
   wire [3:0] presc_sel  = applied_control[rtcpit_pkg::CTRL_PRESC_HI:rtcpit_pkg::CTRL_PRESC_LO];
   wire       tick_on    = applied_tick[rtcpit_pkg::TICK_ENABLE_BIT];
   wire [3:0] tick_sel   = applied_tick[rtcpit_pkg::TICK_PERIOD_HI:rtcpit_pkg::TICK_PERIOD_LO];
   wire       cnt_halted = debug_halt_in & ~halt_behaviour[0];
   wire       tick_halted = debug_halt_in & ~tick_halt_behaviour[0];

   // Counter runs in idle, in standby only if kept running
   wire cnt_run  = cnt_on & (~standby_in | keep_stby) & ~cnt_halted;
   // Tick timer ignores sleep state
   wire tick_run = tick_on & ~tick_halted;
   wire presc_on = cnt_on | tick_on;

   // Divide by two to the n: step when low n prescaler bits are all ones
   wire [PW-1:0] presc_mask = PW'((16'h0001 << presc_sel) - 16'h0001);
   wire          cnt_step   = slow_edge & cnt_run
                              & ((prescaler & presc_mask) == presc_mask);

   wire          at_limit   = (running_count == applied_limit);
   wire [15:0]   next_count = at_limit ? 16'h0000 : running_count + 16'h0001;
   wire          wrap_evt   = cnt_step & at_limit;
   wire          match_evt  = cnt_step & (next_count == applied_match);

   // Tick when prescaler bit p rises, p 1 to 14 (0 and 15 give none); period two to the p+1 slow cycles
   wire [PW-1:0] tick_mask  = PW'((16'h0001 << tick_sel) - 16'h0001);
   wire          tick_bit   = (tick_sel < 4'(PW)) ? prescaler[tick_sel] : 1'b1;
   wire          tick_evt   = slow_edge & tick_run & (tick_sel != 4'h0)
                              & ~tick_bit & ((prescaler & tick_mask) == tick_mask);

   // Slow-side state, advanced only on timebase edges
   always_ff @(posedge clk_in or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         applied_control <= rtcpit_pkg::RESET_BYTE;
         applied_limit   <= rtcpit_pkg::RESET_LIMIT;
         applied_match   <= rtcpit_pkg::RESET_WORD;
         applied_tick    <= rtcpit_pkg::RESET_BYTE;
      end else begin
         if (sync_apply[rtcpit_pkg::SYNC_CONTROL])
            applied_control <= timekeeper_control;
         if (sync_apply[rtcpit_pkg::SYNC_LIMIT])
            applied_limit <= wrap_limit;
         if (sync_apply[rtcpit_pkg::SYNC_MATCH])
            applied_match <= match_value;
         if (sync_apply[rtcpit_pkg::SYNC_TICK])
            applied_tick <= tick_control;
      end
   end

   always_ff @(posedge clk_in or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         prescaler     <= '0;
         running_count <= rtcpit_pkg::RESET_WORD;
      end else begin
         if (!presc_on)
            prescaler <= '0;
         else if (slow_edge)
            prescaler <= prescaler + PW'(1);
         if (sync_apply[rtcpit_pkg::SYNC_COUNT])
            running_count <= count_written;
         else if (cnt_step)
            running_count <= next_count;
      end
   end

   // Control and data registers
   always_ff @(posedge clk_in or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         timekeeper_control  <= rtcpit_pkg::RESET_BYTE;
         event_enable        <= rtcpit_pkg::RESET_BYTE;
         byte_staging        <= rtcpit_pkg::RESET_BYTE;
         halt_behaviour      <= rtcpit_pkg::RESET_BYTE;
         source_select       <= rtcpit_pkg::RESET_BYTE;
         tick_control        <= rtcpit_pkg::RESET_BYTE;
         tick_event_enable   <= rtcpit_pkg::RESET_BYTE;
         tick_halt_behaviour <= rtcpit_pkg::RESET_BYTE;
      end else begin
         if (wr_ctrl)  timekeeper_control  <= wd;
         if (wr_en)    event_enable        <= {6'h00, wd[1:0]};
         if (wr_stage) byte_staging        <= wd;
         if (wr_halt)  halt_behaviour      <= {7'h00, wd[0]};
         if (wr_src)   source_select       <= {6'h00, wd[1:0]};
         if (wr_tick)  tick_control        <= {1'b0, wd[6:3], 2'h0, wd[0]};
         if (wr_ten)   tick_event_enable   <= {7'h00, wd[0]};
         if (wr_thalt) tick_halt_behaviour <= {7'h00, wd[0]};
      end
   end

   always_ff @(posedge clk_in or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         wrap_limit    <= rtcpit_pkg::RESET_LIMIT;
         match_value   <= rtcpit_pkg::RESET_WORD;
         count_written <= rtcpit_pkg::RESET_WORD;
      end else begin
         if (wr_lim_lo) wrap_limit[7:0]     <= wd;
         if (wr_lim_hi) wrap_limit[15:8]    <= wd;
         if (wr_mat_lo) match_value[7:0]    <= wd;
         if (wr_mat_hi) match_value[15:8]   <= wd;
         if (wr_cnt_lo) count_written[7:0]  <= wd;
         if (wr_cnt_hi) count_written[15:8] <= wd;
      end
   end

   // Event flags: each slow event is one bus-cycle pulse, set wins over clear
   wire [1:0] flag_set   = {match_evt, wrap_evt};
   wire [1:0] flag_clr   = wr_flags ? wd[1:0] : 2'h0;
   wire [1:0] next_flags = flag_set | (event_flags & ~flag_clr);
   wire       next_tflag = tick_evt | (tick_event_flag & ~(wr_tflag & wd[rtcpit_pkg::TICK_BIT]));
   // Requests follow an enable write in the same cycle
   wire [1:0] next_enable  = wr_en ? wd[1:0] : event_enable[1:0];
   wire       next_tenable = wr_ten ? wd[rtcpit_pkg::TICK_BIT] : tick_event_enable[rtcpit_pkg::TICK_BIT];

   always_ff @(posedge clk_in or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         event_flags     <= 2'h0;
         tick_event_flag <= 1'b0;
         counter_irq_out <= 1'b0;
         tick_irq_out    <= 1'b0;
      end else begin
         event_flags     <= next_flags;
         tick_event_flag <= next_tflag;
         counter_irq_out <= |(next_flags & next_enable);
         tick_irq_out    <= next_tflag & next_tenable;
      end
   end

   // Read selection
   logic [7:0] rd_byte;
   always_comb begin
      case (idx)
         rtcpit_pkg::IDX_CONTROL:     rd_byte = timekeeper_control;
         rtcpit_pkg::IDX_SYNC_STATE:  rd_byte = {4'h0, sync_busy[3:0]};
         rtcpit_pkg::IDX_ENABLE:      rd_byte = event_enable;
         rtcpit_pkg::IDX_FLAGS:       rd_byte = {6'h00, event_flags};
         rtcpit_pkg::IDX_STAGING:     rd_byte = byte_staging;
         rtcpit_pkg::IDX_HALT:        rd_byte = halt_behaviour;
         rtcpit_pkg::IDX_SOURCE:      rd_byte = source_select;
         rtcpit_pkg::IDX_COUNT_LO:    rd_byte = running_count[7:0];
         rtcpit_pkg::IDX_COUNT_HI:    rd_byte = running_count[15:8];
         rtcpit_pkg::IDX_LIMIT_LO:    rd_byte = wrap_limit[7:0];
         rtcpit_pkg::IDX_LIMIT_HI:    rd_byte = wrap_limit[15:8];
         rtcpit_pkg::IDX_MATCH_LO:    rd_byte = match_value[7:0];
         rtcpit_pkg::IDX_MATCH_HI:    rd_byte = match_value[15:8];
         rtcpit_pkg::IDX_TICK_CTRL:   rd_byte = tick_control;
         rtcpit_pkg::IDX_TICK_SYNC:   rd_byte = {7'h00, sync_busy[rtcpit_pkg::SYNC_TICK]};
         rtcpit_pkg::IDX_TICK_ENABLE: rd_byte = tick_event_enable;
         rtcpit_pkg::IDX_TICK_FLAGS:  rd_byte = {7'h00, tick_event_flag};
         rtcpit_pkg::IDX_TICK_HALT:   rd_byte = tick_halt_behaviour;
         default:                     rd_byte = 8'h00;
      endcase
   end

   // Waitrequest: one wait cycle, then answer for one cycle
   always_ff @(posedge clk_in or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         waitrequest_out <= 1'b1;
         readdata_out    <= 32'h0000_0000;
      end else begin
         waitrequest_out <= ~req;
         if (req)
            readdata_out <= {24'h00_0000, rd_byte};
         else if (done)
            readdata_out <= 32'h0000_0000;
      end
   end
endmodule : rtcpit_top

// >>> rtcpit_checker.sv
// Checker for the bus and request ports of the timekeeping block.
// Assumes binding to rtcpit_top; sees only its ports.
`timescale 1ns/10ps
module rtcpit_checker (
   // Clock and reset
   input wire logic        clk_in,
   input wire logic        rst_b_in,
   // Register bus
   input wire logic [6:0]  address_in,
   input wire logic        read_in,
   input wire logic        write_in,
   input wire logic [31:0] writedata_in,
   input wire logic [3:0]  byteenable_in,
   input wire logic [31:0] readdata_out,
   input wire logic        waitrequest_out,
   // Requests
   input wire logic        counter_irq_out,
   input wire logic        tick_irq_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   wire logic [4:0] idx   = address_in[6:2];
   wire logic       wr_ok = write_in && !waitrequest_out && byteenable_in[0];
   wire logic       rd_ok = read_in && !waitrequest_out;

   a_wait_one_cycle: assert property ((read_in || write_in) && waitrequest_out |=> !waitrequest_out)
      else $error("bus answer late");
   a_wait_low_once: assert property (!waitrequest_out |=> waitrequest_out)
      else $error("waitrequest low too long");
   a_wait_has_cause: assert property ($fell(waitrequest_out) |-> $past(read_in || write_in))
      else $error("answer without request");
   a_idle_data_zero: assert property (waitrequest_out |-> readdata_out == 32'h0000_0000)
      else $error("read data outside answer");
   a_status_reserved: assert property (rd_ok && idx == 5'h01 |-> readdata_out[31:4] == 28'h000_0000)
      else $error("status reserved bits set");
   a_tick_status_bits: assert property (rd_ok && idx == 5'h11 |-> readdata_out[31:1] == 31'h0000_0000)
      else $error("tick status reserved bits set");
   a_irq_off_enable: assert property (wr_ok && idx == 5'h02 && writedata_in[1:0] == 2'b00 |=> !counter_irq_out)
      else $error("counter request without enable");
   a_tick_irq_off: assert property (wr_ok && idx == 5'h12 && !writedata_in[0] |=> !tick_irq_out)
      else $error("tick request without enable");
   a_irq_held: assert property ($fell(counter_irq_out) |-> $past(wr_ok))
      else $error("counter request dropped by itself");
   a_tick_irq_held: assert property ($fell(tick_irq_out) |-> $past(wr_ok))
      else $error("tick request dropped by itself");
endmodule : rtcpit_checker

bind rtcpit_top rtcpit_checker u_checker (.clk_in, .rst_b_in, .address_in, .read_in, .write_in, .writedata_in,
   .byteenable_in, .readdata_out, .waitrequest_out, .counter_irq_out, .tick_irq_out);

// >>> test_rtc_counter_and_tick_timer.sv
// Self-checking bench for the timekeeping counter and tick timer.
// Assumes rtcpit_top; slow timebase is made here at one eighth of clk_in.
`timescale 1ns/10ps
module test_rtc_counter_and_tick_timer;
   logic        clk_in, rst_b_in, read_in, write_in, slow_clk_in, standby_in, debug_halt_in;
   logic [6:0]  address_in;
   logic [31:0] writedata_in, readdata_out;
   logic [3:0]  byteenable_in;
   logic        waitrequest_out, counter_irq_out, tick_irq_out;
   logic [2:0]  div;
   logic [7:0]  v;
   int          n_errors, check_count;
   logic [4:0]  t_idx [7] = '{5'h0b, 5'h0a, 5'h0d, 5'h0c, 5'h08, 5'h00, 5'h10};
   logic [7:0]  t_dat [7] = '{8'h00, 8'hff, 8'h00, 8'h03, 8'h00, 8'h01, 8'h09};
   logic [4:0]  t_st  [7] = '{5'h01, 5'h01, 5'h01, 5'h01, 5'h01, 5'h01, 5'h11};
   logic [7:0]  t_bit [7] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h02, 8'h01, 8'h01};

   rtcpit_top DUT (.clk_in, .rst_b_in, .address_in, .read_in, .write_in, .writedata_in, .byteenable_in,
      .readdata_out, .waitrequest_out, .slow_clk_in, .standby_in, .debug_halt_in, .counter_irq_out, .tick_irq_out);

   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      div <= div + 3'h1;
      slow_clk_in <= div[2];
   end

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_of_test

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic bus(input logic rd, input logic [4:0] idx, input logic [7:0] d, input logic [3:0] be,
                      output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk_in);
      address_in <= {idx, 2'b00};
      writedata_in <= {24'h00_0000, d};
      byteenable_in <= be;
      read_in <= rd;
      write_in <= !rd;
      do begin
         @(posedge clk_in);
         n++;
      end while (waitrequest_out !== 1'b0 && n < 20);
      q = readdata_out[7:0];
      read_in <= 1'b0;
      write_in <= 1'b0;
      if (n >= 20) begin
         check("bus answer", 8'h00, 8'h01);
         end_of_test();
      end
   endtask : bus

   task automatic wr(input logic [4:0] idx, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b0, idx, d, 4'h1, q);
   endtask : wr

   task automatic rdchk(input string what, input logic [4:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b1, idx, 8'h00, 4'h1, q);
      check(what, q, exp);
   endtask : rdchk

   task automatic wait_idle(input logic [4:0] idx);
      logic [7:0] q;
      int n;
      n = 0;
      do begin
         bus(1'b1, idx, 8'h00, 4'h1, q);
         n++;
      end while (q !== 8'h00 && n < 100);
      check("sync idle", q, 8'h00);
      if (q !== 8'h00) end_of_test();
   endtask : wait_idle

   // Count advance over 64 bus cycles, eight slow periods
   task automatic rate(input string what, input logic [7:0] exp);
      logic [7:0] a, b;
      bus(1'b1, 5'h08, 8'h00, 4'h1, a);
      repeat (61) @(posedge clk_in);
      bus(1'b1, 5'h08, 8'h00, 4'h1, b);
      check(what, b - a, exp);
   endtask : rate

   initial begin
      rst_b_in = 1'b0;
      read_in = 1'b0;
      write_in = 1'b0;
      address_in = 7'h00;
      writedata_in = 32'h0000_0000;
      byteenable_in = 4'h0;
      standby_in = 1'b0;
      debug_halt_in = 1'b0;
      div = 3'h0;
      slow_clk_in = 1'b0;
      n_errors = 0;
      check_count = 0;
      repeat (12) @(posedge clk_in);
      rst_b_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      for (int i = 0; i < 22; i++) rdchk("reset value", i[4:0], (i == 10 || i == 11) ? 8'hff : 8'h00);
      wr(5'h04, 8'h5a);
      bus(1'b0, 5'h04, 8'ha5, 4'h2, v);
      rdchk("staging", 5'h04, 8'h5a);
      $display("test reset_map done");
      for (int i = 0; i < 7; i++) begin
         wr(t_idx[i], t_dat[i]);
         rdchk("busy bit", t_st[i], t_bit[i]);
         wait_idle(t_st[i]);
      end
      $display("test sync done");
      for (int p = 0; p < 3; p++) begin
         wr(5'h00, {1'b0, p[3:0], 3'b001});
         wait_idle(5'h01);
         rate("count rate", 8'h08 >> p);
      end
      wr(5'h00, 8'h00);
      wait_idle(5'h01);
      rate("stopped count", 8'h00);
      $display("test rate done");
      standby_in <= 1'b1;
      wr(5'h00, 8'h01);
      wait_idle(5'h01);
      rate("standby stop", 8'h00);
      wr(5'h00, 8'h81);
      wait_idle(5'h01);
      rate("standby run", 8'h08);
      wr(5'h13, 8'h01);
      repeat (80) @(posedge clk_in);
      rdchk("tick flag", 5'h13, 8'h01);
      wr(5'h12, 8'h01);
      @(negedge clk_in);
      check("tick request", {7'h00, tick_irq_out}, 8'h01);
      wr(5'h12, 8'h00);
      standby_in <= 1'b0;
      $display("test standby done");
      debug_halt_in <= 1'b1;
      rate("halted count", 8'h00);
      wr(5'h05, 8'h01);
      rate("halt run", 8'h08);
      debug_halt_in <= 1'b0;
      wr(5'h05, 8'h00);
      $display("test halt done");
      repeat (2200) @(posedge clk_in);
      rdchk("event flags", 5'h03, 8'h03);
      check("masked request", {7'h00, counter_irq_out}, 8'h00);
      wr(5'h00, 8'h00);
      wait_idle(5'h01);
      wr(5'h02, 8'h03);
      @(negedge clk_in);
      check("counter request", {7'h00, counter_irq_out}, 8'h01);
      wr(5'h03, 8'h02);
      rdchk("clear one flag", 5'h03, 8'h01);
      wr(5'h03, 8'h00);
      rdchk("zero write keeps", 5'h03, 8'h01);
      check("request held", {7'h00, counter_irq_out}, 8'h01);
      wr(5'h03, 8'h01);
      @(negedge clk_in);
      check("request cleared", {7'h00, counter_irq_out}, 8'h00);
      rdchk("flags clear", 5'h03, 8'h00);
      wr(5'h02, 8'h00);
      $display("test flags done");
      end_of_test();
   end
endmodule : test_rtc_counter_and_tick_timer
